/* rtl/tscc_cfg.svh */
// constants and rule summary for the trigger, sampling and statistics block
// Summary of operation
// - free run samples at fixed rate, ignores trigger
// - continuous mode samples on each trigger or on auto timeout
// - single request samples once if triggered
// - run/stop toggles; stopped holds results
// - second channel mode ignored if single-channel
// - source selects channel A, B or external
// - channel trigger follows envelope versus threshold
// - external source comes from rear input pin
// - auto mode samples anyway after timeout
// - normal mode waits forever for trigger
// - auto level threshold is top minus 3 dB
// - manual threshold spans -40 to +20 dBm
// - auto level locks manual, reports computed threshold
// - retrigger_inhibit_time suppresses triggers after each trigger
// - slope picks rising or falling transition
// - chosen channel trigger drives rear output pulse
// - table: average, peak, ratio, six probability powers; code keeps count, sum, peak and one count above the power set
// - power set gives probability, probability gives power; code only counts samples above the power set
// - time termination limit up to 1 h
// - point count limit up to 4200.0M points
// - both limits: first one reached terminates
// - termination action stop, clear or halve
`ifndef TSCC_CFG_SVH
`define TSCC_CFG_SVH
`define TSCC_CLK_HZ 10000000
// power values in centi-dBm, signed 16 bit
`define TSCC_LVL_MIN (-16'sd4000)
`define TSCC_LVL_MAX (16'sd2000)
`define TSCC_AUTO_DROP (16'sd300)
`define TSCC_LVL_RESET (16'sd0)
`define TSCC_AUTO_TIMEOUT_MS 100
`define TSCC_AUTO_TIMEOUT_CYC ((`TSCC_AUTO_TIMEOUT_MS * `TSCC_CLK_HZ) / 1000)
`define TSCC_TERM_TIME_MAX_S 3600
`define TSCC_TERM_CNT_MAX 64'd4200000000
`define TSCC_ONE_SEC_CYC `TSCC_CLK_HZ
`define TSCC_NUM_PROB 6
`endif

/* rtl/tscc_pkg.sv */
// types shared by the trigger and statistics block
package tscc_pkg;
  typedef enum logic [1:0] {
    TSCC_FREE = 2'b00,
    TSCC_CONT = 2'b01,
    TSCC_SINGLE = 2'b10
  } tscc_acq_e;
  typedef enum logic [1:0] {
    TSCC_AUTO = 2'b00,
    TSCC_NORM = 2'b01,
    TSCC_AUTOLVL = 2'b10
  } tscc_trig_e;
  typedef enum logic [1:0] {
    TSCC_SRC_A = 2'b00,
    TSCC_SRC_B = 2'b01,
    TSCC_SRC_EXT = 2'b10
  } tscc_src_e;
  typedef enum logic [1:0] {
    TSCC_ACT_STOP = 2'b00,
    TSCC_ACT_CLEAR = 2'b01,
    TSCC_ACT_HALVE = 2'b10
  } tscc_act_e;
  typedef struct packed {
    tscc_acq_e acq_a;
    tscc_acq_e acq_b;
    tscc_trig_e trig_mode;
    tscc_src_e src;
    logic slope_neg;
    logic out_sel_b;
    logic signed [15:0] manual_level;
    logic [31:0] retrigger_inhibit_time_cyc;
  } tscc_trig_cfg_s;
  typedef struct packed {
    logic time_en;
    logic [11:0] time_s;
    logic cnt_en;
    logic [31:0] cnt_max;
    tscc_act_e action;
  } tscc_term_cfg_s;
endpackage : tscc_pkg

/* rtl/tscc_stat.sv */
// statistics accumulation with time and point-count termination
`timescale 1ns/1ps
`include "tscc_cfg.svh"
module tscc_stat (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire tscc_pkg::tscc_term_cfg_s cfg_in,
  input wire logic run_in,
  input wire logic sample_valid_in,
  input wire logic signed [15:0] sample_in,
  input wire logic signed [15:0] power_set_in,
  output logic [31:0] count_out,
  output logic signed [15:0] peak_out,
  output logic signed [31:0] sum_high_out,
  output logic [31:0] above_set_out,
  output logic terminated_out,
  output logic term_pulse_out
);
  logic [31:0] count;
  logic [31:0] above;
  logic signed [47:0] sum;
  logic signed [15:0] peak;
  logic [23:0] sec_div;
  logic [11:0] secs;
  logic stopped;
  logic hit;
  logic accept;

  assign accept = run_in && sample_valid_in && !stopped;
  // first limit reached wins
  assign hit = accept && ((cfg_in.cnt_en && (count + 32'h1 >= cfg_in.cnt_max))
    || (cfg_in.time_en && (secs >= cfg_in.time_s)));

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sec_div <= 24'h0;
      secs <= 12'h0;
    end
    else if (hit && cfg_in.action != tscc_pkg::TSCC_ACT_STOP)
    begin
      sec_div <= 24'h0;
      secs <= 12'h0;
    end
    else if (run_in && !stopped)
    begin
      if (sec_div == 24'(`TSCC_ONE_SEC_CYC - 1))
      begin
        sec_div <= 24'h0;
        secs <= secs + 12'h1;
      end
      else
        sec_div <= sec_div + 24'h1;
    end
  end

  // termination action
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      count <= 32'h0;
      above <= 32'h0;
      sum <= 48'sh0;
      peak <= `TSCC_LVL_MIN;
      stopped <= 1'b0;
    end
    else if (hit)
    begin
      case (cfg_in.action)
        tscc_pkg::TSCC_ACT_STOP:
        begin
          // the sample that reaches the limit is still counted before the freeze
          stopped <= 1'b1;
          count <= count + 32'h1;
          sum <= sum + 48'(sample_in);
          if (sample_in > peak)
            peak <= sample_in;
          if (sample_in > power_set_in)
            above <= above + 32'h1;
        end
        tscc_pkg::TSCC_ACT_CLEAR:
        begin
          count <= 32'h0;
          above <= 32'h0;
          sum <= 48'sh0;
          peak <= `TSCC_LVL_MIN;
        end
        tscc_pkg::TSCC_ACT_HALVE:
        begin
          // halving keeps the older half in proportion, accumulation carries on
          count <= count >> 1;
          above <= above >> 1;
          sum <= sum >>> 1;
        end
        default: stopped <= 1'b1;
      endcase
    end
    else if (accept)
    begin
      count <= count + 32'h1;
      sum <= sum + 48'(sample_in);
      if (sample_in > peak)
        peak <= sample_in;
      // probability numerator for user power level
      if (sample_in > power_set_in)
        above <= above + 32'h1;
    end
    else if (!run_in)
      stopped <= 1'b0;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      term_pulse_out <= 1'b0;
    else
      term_pulse_out <= hit;
  end

  assign count_out = count;
  assign above_set_out = above;
  assign peak_out = peak;
  assign sum_high_out = sum[47:16];
  assign terminated_out = stopped;

  chk_stop_holds: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    stopped && run_in |=> $stable(count)) else $error("count moved while stopped");
  chk_count_limit: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    cfg_in.cnt_en && cfg_in.cnt_max != 32'h0 && $stable(cfg_in) |-> count <= cfg_in.cnt_max)
    else $error("count passed limit");
endmodule : tscc_stat

/* rtl/tscc_top.sv */
// trigger, sampling control and statistics for a two-channel sensor path
`timescale 1ns/1ps
`include "tscc_cfg.svh"
module tscc_top #(
  parameter int unsigned AUTO_TIMEOUT_CYC = `TSCC_AUTO_TIMEOUT_CYC,
  parameter bit TWO_CHANNELS = 1'b1
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire tscc_pkg::tscc_trig_cfg_s trig_cfg_in,
  input wire tscc_pkg::tscc_term_cfg_s term_cfg_in,
  input wire logic run_toggle_in,
  input wire logic single_req_in,
  input wire logic stat_run_in,
  input wire logic sample_valid_in,
  input wire logic signed [15:0] power_a_in,
  input wire logic signed [15:0] power_b_in,
  input wire logic ext_trig_in,
  input wire logic signed [15:0] power_set_in,
  output logic running_out,
  output logic trig_pulse_out,
  output logic acquire_out,
  output logic signed [15:0] held_a_out,
  output logic signed [15:0] held_b_out,
  output logic signed [15:0] level_report_out,
  output logic trig_ttl_out,
  output logic [31:0] stat_count_out,
  output logic signed [15:0] stat_peak_out,
  output logic signed [31:0] stat_sum_out,
  output logic [31:0] stat_above_out,
  output logic stat_done_out,
  output logic stat_term_out
);
  logic running;
  logic [2:0] ext_sync;
  logic ext_lvl;
  logic signed [15:0] top_a;
  logic signed [15:0] top_b;
  logic signed [15:0] level;
  logic signed [15:0] manual_clamped;
  logic chan_a_trig;
  logic chan_b_trig;
  logic src_now;
  logic src_prev;
  logic edge_hit;
  logic [31:0] retrigger_inhibit_time_cnt;
  logic retrigger_inhibit_time_busy;
  logic trig_pulse;
  logic [31:0] auto_cnt;
  logic auto_fire;
  logic single_armed;
  logic acquire;
  tscc_pkg::tscc_acq_e mode_a;
  tscc_pkg::tscc_acq_e mode_b;

  // run/stop toggles on each request
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      running <= 1'b1;
    else if (run_toggle_in)
      running <= !running;
  end
  assign running_out = running;

  // external trigger pin, three stages, change accepted when last two agree
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ext_sync <= 3'h0;
      ext_lvl <= 1'b0;
    end
    else
    begin
      ext_sync <= {ext_sync[1:0], ext_trig_in};
      if (ext_sync[1] == ext_sync[2])
        ext_lvl <= ext_sync[2];
    end
  end

  // track pulse top per channel; decays slowly so level follows changes
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      top_a <= `TSCC_LVL_MIN;
      top_b <= `TSCC_LVL_MIN;
    end
    else if (sample_valid_in)
    begin
      // equal power holds the top, otherwise a flat top would wobble by one
      top_a <= (power_a_in >= top_a) ? power_a_in : top_a - 16'sd1;
      top_b <= (power_b_in >= top_b) ? power_b_in : top_b - 16'sd1;
    end
  end

  // manual level clamped to its range
  always_comb
  begin
    manual_clamped = trig_cfg_in.manual_level;
    if (trig_cfg_in.manual_level < `TSCC_LVL_MIN)
      manual_clamped = `TSCC_LVL_MIN;
    else if (trig_cfg_in.manual_level > `TSCC_LVL_MAX)
      manual_clamped = `TSCC_LVL_MAX;
  end

  // auto level: top of selected channel minus 3 dB, manual ignored
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      level <= `TSCC_LVL_RESET;
    else if (trig_cfg_in.trig_mode == tscc_pkg::TSCC_AUTOLVL)
      level <= (trig_cfg_in.src == tscc_pkg::TSCC_SRC_B ? top_b : top_a) - `TSCC_AUTO_DROP;
    else
      level <= manual_clamped;
  end
  assign level_report_out = level;

  // internal channel triggers are the envelope compared to level
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      chan_a_trig <= 1'b0;
      chan_b_trig <= 1'b0;
    end
    else if (sample_valid_in)
    begin
      chan_a_trig <= power_a_in > level;
      chan_b_trig <= TWO_CHANNELS && (power_b_in > level);
    end
  end

  // source selection
  always_comb
  begin
    case (trig_cfg_in.src)
      tscc_pkg::TSCC_SRC_A: src_now = chan_a_trig;
      tscc_pkg::TSCC_SRC_B: src_now = chan_b_trig;
      tscc_pkg::TSCC_SRC_EXT: src_now = ext_lvl;
      default: src_now = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      src_prev <= 1'b0;
    else
      src_prev <= src_now;
  end

  // slope selects rising or falling transition
  assign edge_hit = trig_cfg_in.slope_neg ? (src_prev && !src_now) : (!src_prev && src_now);

  // one-cycle trigger pulse outside retrigger_inhibit_time
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      trig_pulse <= 1'b0;
    else
      trig_pulse <= edge_hit && !retrigger_inhibit_time_busy;
  end
  assign trig_pulse_out = trig_pulse;

  // retrigger_inhibit_time counts down after each accepted trigger
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      retrigger_inhibit_time_cnt <= 32'h0;
    else if (edge_hit && !retrigger_inhibit_time_busy)
      retrigger_inhibit_time_cnt <= trig_cfg_in.retrigger_inhibit_time_cyc;
    else if (retrigger_inhibit_time_busy)
      retrigger_inhibit_time_cnt <= retrigger_inhibit_time_cnt - 32'h1;
  end
  assign retrigger_inhibit_time_busy = retrigger_inhibit_time_cnt != 32'h0;

  // rear output follows the chosen channel trigger as a pulse
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      trig_ttl_out <= 1'b0;
    else
      trig_ttl_out <= trig_cfg_in.out_sel_b ? chan_b_trig : chan_a_trig;
  end

  // single-channel build forces channel B mode to free run
  assign mode_a = trig_cfg_in.acq_a;
  assign mode_b = TWO_CHANNELS ? trig_cfg_in.acq_b : tscc_pkg::TSCC_FREE;

  // auto timeout: acquire without trigger after the wait
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      auto_cnt <= 32'h0;
    else if (trig_pulse || auto_fire)
      auto_cnt <= 32'h0;
    else
      auto_cnt <= auto_cnt + 32'h1;
  end
  // normal mode never self-fires
  assign auto_fire = (trig_cfg_in.trig_mode != tscc_pkg::TSCC_NORM)
    && (auto_cnt >= AUTO_TIMEOUT_CYC - 1);

  // single request arms one acquisition; cleared only by a trigger
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      single_armed <= 1'b0;
    else if (single_req_in)
      single_armed <= 1'b1;
    else if (trig_pulse)
      single_armed <= 1'b0;
  end

  always_comb
  begin
    case (mode_a)
      tscc_pkg::TSCC_FREE: acquire = sample_valid_in;
      tscc_pkg::TSCC_CONT: acquire = trig_pulse || auto_fire;
      tscc_pkg::TSCC_SINGLE: acquire = single_armed && trig_pulse;
      default: acquire = 1'b0;
    endcase
    acquire = acquire && running;
  end
  assign acquire_out = acquire;

  // held results refresh only while running
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      held_a_out <= `TSCC_LVL_MIN;
      held_b_out <= `TSCC_LVL_MIN;
    end
    else
    begin
      if (acquire)
        held_a_out <= power_a_in;
      if (running && TWO_CHANNELS && (mode_b == tscc_pkg::TSCC_FREE ? sample_valid_in : acquire))
        held_b_out <= power_b_in;
    end
  end

  // statistics on channel A samples
  tscc_stat u_stat (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .cfg_in(term_cfg_in),
    .run_in(stat_run_in),
    .sample_valid_in(sample_valid_in),
    .sample_in(power_a_in),
    .power_set_in(power_set_in),
    .count_out(stat_count_out),
    .peak_out(stat_peak_out),
    .sum_high_out(stat_sum_out),
    .above_set_out(stat_above_out),
    .terminated_out(stat_done_out),
    .term_pulse_out(stat_term_out)
  );

  chk_free_ignore: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    mode_a == tscc_pkg::TSCC_FREE && running |-> acquire == sample_valid_in)
    else $error("free run not at sample rate");
  chk_cont_trig: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    mode_a == tscc_pkg::TSCC_CONT && acquire |-> trig_pulse || auto_fire)
    else $error("continuous acquired without cause");
  chk_single_once: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    mode_a == tscc_pkg::TSCC_SINGLE && acquire && !single_req_in |=> !single_armed)
    else $error("single stayed armed");
  chk_stop_hold: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !running |=> $stable(held_a_out)) else $error("held result moved while stopped");
  chk_norm_wait: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    trig_cfg_in.trig_mode == tscc_pkg::TSCC_NORM |-> !auto_fire)
    else $error("normal mode self fired");
  chk_retrigger_inhibit_time_gap: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    trig_pulse && trig_cfg_in.retrigger_inhibit_time_cyc > 32'h2 && $stable(trig_cfg_in) |=> !trig_pulse [*2])
    else $error("trigger inside retrigger_inhibit_time");
  chk_trig_single: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    trig_pulse |=> !trig_pulse) else $error("trigger pulse too long");
  chk_level_range: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    trig_cfg_in.trig_mode != tscc_pkg::TSCC_AUTOLVL && $stable(trig_cfg_in) |=>
    level >= `TSCC_LVL_MIN && level <= `TSCC_LVL_MAX) else $error("level out of range");
  cov_cont: cover property (@(posedge ref_clk_in) mode_a == tscc_pkg::TSCC_CONT && trig_pulse);
  cov_auto: cover property (@(posedge ref_clk_in) auto_fire && running);
  cov_single: cover property (@(posedge ref_clk_in) mode_a == tscc_pkg::TSCC_SINGLE && acquire);
  cov_term: cover property (@(posedge ref_clk_in) stat_term_out);
endmodule : tscc_top

/* bench/tscc_sensor_model.sv */
// behavioural model of the two sensor channels and the external trigger source
`timescale 1ns/1ps
module tscc_sensor_model (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic valid_en_in,
  input wire logic pulse_a_in,
  input wire logic pulse_b_in,
  input wire logic pulse_x_in,
  output logic sample_valid_out,
  output logic signed [15:0] power_a_out,
  output logic signed [15:0] power_b_out,
  output logic ext_trig_out
);
  // pulse top and floor; the threshold under test sits between them
  localparam logic signed [15:0] TOP = 16'sh03E8;
  localparam logic signed [15:0] BASE = -16'sh07D0;
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sample_valid_out <= 1'b0;
      power_a_out <= BASE;
      power_b_out <= BASE;
      ext_trig_out <= 1'b0;
    end
    else
    begin
      // valid_en low lets the bench model a slow sensor
      sample_valid_out <= valid_en_in;
      power_a_out <= pulse_a_in ? TOP : BASE;
      power_b_out <= pulse_b_in ? TOP : BASE;
      ext_trig_out <= pulse_x_in;
    end
  end
endmodule : tscc_sensor_model

/* bench/tb_top.sv */
// self-checking bench for trigger, sampling and statistics control
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    tscc_pkg::tscc_acq_e acq;
    tscc_pkg::tscc_trig_e tm;
    tscc_pkg::tscc_src_e src;
    logic neg;
    int hold;
    int sel;
    int n;
    int t_lo;
    int t_hi;
    int a_lo;
    int a_hi;
  } tscc_row_s;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  tscc_pkg::tscc_trig_cfg_s trig_cfg = '0;
  tscc_pkg::tscc_term_cfg_s term_cfg = '0;
  logic run_toggle = 1'b0;
  logic single_req = 1'b0;
  logic stat_run = 1'b0;
  logic valid_en = 1'b1;
  logic pulse_a = 1'b0;
  logic pulse_b = 1'b0;
  logic pulse_x = 1'b0;
  logic counting = 1'b0;
  logic signed [15:0] power_set = -16'sh0BB8;
  logic sample_valid, ext_trig, running, trig_pulse, acquire, trig_ttl, stat_done, stat_term;
  logic signed [15:0] power_a, power_b, held_a, held_b, level_report, stat_peak;
  logic signed [31:0] stat_sum;
  logic [31:0] stat_count, stat_above;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int n_trig = 0;
  int n_acq = 0;
  tscc_row_s rows[9] = '{
    '{tscc_pkg::TSCC_FREE, tscc_pkg::TSCC_NORM, tscc_pkg::TSCC_SRC_A, 0, 0, 0, 3, 0, 999, 95, 100},
    '{tscc_pkg::TSCC_CONT, tscc_pkg::TSCC_NORM, tscc_pkg::TSCC_SRC_A, 0, 0, 0, 3, 3, 3, 3, 3},
    '{tscc_pkg::TSCC_CONT, tscc_pkg::TSCC_NORM, tscc_pkg::TSCC_SRC_B, 0, 0, 0, 3, 0, 0, 0, 0},
    '{tscc_pkg::TSCC_CONT, tscc_pkg::TSCC_NORM, tscc_pkg::TSCC_SRC_B, 0, 0, 1, 3, 3, 3, 3, 3},
    '{tscc_pkg::TSCC_CONT, tscc_pkg::TSCC_NORM, tscc_pkg::TSCC_SRC_EXT, 0, 0, 2, 3, 3, 3, 3, 3},
    '{tscc_pkg::TSCC_CONT, tscc_pkg::TSCC_NORM, tscc_pkg::TSCC_SRC_A, 1, 0, 0, 3, 3, 3, 3, 3},
    '{tscc_pkg::TSCC_CONT, tscc_pkg::TSCC_NORM, tscc_pkg::TSCC_SRC_A, 0, 0, 0, 0, 0, 0, 0, 0},
    '{tscc_pkg::TSCC_CONT, tscc_pkg::TSCC_AUTO, tscc_pkg::TSCC_SRC_A, 0, 0, 0, 0, 0, 999, 2, 6},
    '{tscc_pkg::TSCC_CONT, tscc_pkg::TSCC_NORM, tscc_pkg::TSCC_SRC_A, 0, 30, 0, 3, 1, 1, 1, 1}
  };
  tscc_sensor_model model (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .valid_en_in(valid_en), .pulse_a_in(pulse_a), .pulse_b_in(pulse_b), .pulse_x_in(pulse_x),
    .sample_valid_out(sample_valid), .power_a_out(power_a), .power_b_out(power_b),
    .ext_trig_out(ext_trig));
  tscc_top #(.AUTO_TIMEOUT_CYC(20), .TWO_CHANNELS(1'b1)) dut (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .trig_cfg_in(trig_cfg), .term_cfg_in(term_cfg),
    .run_toggle_in(run_toggle), .single_req_in(single_req), .stat_run_in(stat_run),
    .sample_valid_in(sample_valid), .power_a_in(power_a), .power_b_in(power_b),
    .ext_trig_in(ext_trig), .power_set_in(power_set), .running_out(running),
    .trig_pulse_out(trig_pulse), .acquire_out(acquire), .held_a_out(held_a), .held_b_out(held_b),
    .level_report_out(level_report), .trig_ttl_out(trig_ttl), .stat_count_out(stat_count),
    .stat_peak_out(stat_peak), .stat_sum_out(stat_sum), .stat_above_out(stat_above),
    .stat_done_out(stat_done), .stat_term_out(stat_term));
  always #50 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    if (counting && trig_pulse === 1'b1) n_trig <= n_trig + 1;
    if (counting && acquire === 1'b1) n_acq <= n_acq + 1;
    // ceiling is several times the expected run length
    if (cycles == 8000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic signed [31:0] exp,
                     input logic signed [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : cyc
  // 100-cycle window with n pulses of 5 cycles every 10 on source sel
  task automatic window(input int sel, input int n);
    logic p;
    n_trig = 0;
    n_acq = 0;
    for (int c = 0; c < 100; c++)
    begin
      @(posedge ref_clk_in);
      p = (c / 10 < n) && (c % 10 < 5);
      counting <= 1'b1;
      pulse_a <= p && sel == 0;
      pulse_b <= p && sel == 1;
      pulse_x <= p && sel == 2;
    end
    @(posedge ref_clk_in);
    counting <= 1'b0;
    @(negedge ref_clk_in);
  endtask : window
  task automatic stat_case(input tscc_pkg::tscc_act_e act, input int lo, input int hi);
    int k;
    @(posedge ref_clk_in);
    stat_run <= 1'b0;
    cyc(2);
    term_cfg <= '{1'b0, 12'h000, 1'b1, 32'h0000000A, act};
    stat_run <= 1'b1;
    k = 0;
    @(negedge ref_clk_in);
    while (stat_term !== 1'b1 && k < 100)
    begin
      @(negedge ref_clk_in);
      k++;
    end
    chk_rng("stat term wait", 0, 99, k);
    if (act != tscc_pkg::TSCC_ACT_STOP) chk_rng("stat count", lo, hi, stat_count);
    $display("test stat action %0d done", act);
  endtask : stat_case
  initial
  begin
    trig_cfg.manual_level = 16'sh0000;
    cyc(5);
    @(negedge ref_clk_in);
    chk("running", 1, running);
    chk("held_a", -4000, held_a);
    chk("held_b", -4000, held_b);
    chk("level", 0, level_report);
    cyc(5);
    reset_n_in <= 1'b1;
    trig_cfg.manual_level <= 16'sh01F4;
    cyc(5);
    @(negedge ref_clk_in);
    chk("manual level", 500, level_report);
    $display("test reset done");
    trig_cfg.manual_level <= 16'sh0000;
    foreach (rows[i])
    begin
      trig_cfg.acq_a <= rows[i].acq;
      trig_cfg.acq_b <= rows[i].acq;
      trig_cfg.trig_mode <= rows[i].tm;
      trig_cfg.src <= rows[i].src;
      trig_cfg.slope_neg <= rows[i].neg;
      trig_cfg.retrigger_inhibit_time_cyc <= rows[i].hold;
      cyc(40);
      window(rows[i].sel, rows[i].n);
      chk_rng("trig count", rows[i].t_lo, rows[i].t_hi, n_trig);
      chk_rng("acq count", rows[i].a_lo, rows[i].a_hi, n_acq);
      $display("test row %0d done", i);
    end
    trig_cfg <= '{tscc_pkg::TSCC_SINGLE, tscc_pkg::TSCC_SINGLE, tscc_pkg::TSCC_NORM,
                  tscc_pkg::TSCC_SRC_A, 1'b0, 1'b0, 16'sh0000, 32'h00000000};
    cyc(40);
    window(0, 2);
    chk_rng("single unarmed", 0, 0, n_acq);
    chk("held_a unarmed", 1000, held_a);
    single_req <= 1'b1;
    cyc(1);
    single_req <= 1'b0;
    window(0, 2);
    chk_rng("single armed", 1, 1, n_acq);
    chk("held_a single", 1000, held_a);
    $display("test single done");
    trig_cfg.acq_a <= tscc_pkg::TSCC_CONT;
    run_toggle <= 1'b1;
    cyc(1);
    run_toggle <= 1'b0;
    cyc(2);
    @(negedge ref_clk_in);
    chk("running stop", 0, running);
    window(0, 3);
    chk_rng("stopped acq", 0, 0, n_acq);
    chk("held_a stopped", 1000, held_a);
    run_toggle <= 1'b1;
    cyc(1);
    run_toggle <= 1'b0;
    window(0, 1);
    chk_rng("run acq", 1, 1, n_acq);
    $display("test run stop done");
    pulse_a <= 1'b1;
    cyc(6);
    @(negedge ref_clk_in);
    chk("ttl a high", 1, trig_ttl);
    trig_cfg.out_sel_b <= 1'b1;
    cyc(6);
    @(negedge ref_clk_in);
    chk("ttl b low", 0, trig_ttl);
    trig_cfg.trig_mode <= tscc_pkg::TSCC_AUTOLVL;
    cyc(40);
    @(negedge ref_clk_in);
    chk("auto level", 700, level_report);
    pulse_a <= 1'b0;
    trig_cfg.out_sel_b <= 1'b0;
    cyc(6);
    @(negedge ref_clk_in);
    chk("ttl a low", 0, trig_ttl);
    $display("test ttl and auto level done");
    stat_case(tscc_pkg::TSCC_ACT_STOP, 0, 0);
    cyc(4);
    @(negedge ref_clk_in);
    chk("stat done", 1, stat_done);
    chk("stat count", 10, stat_count);
    chk("stat peak", -2000, stat_peak);
    chk("stat sum", -1, stat_sum);
    chk("stat above", 10, stat_above);
    stat_case(tscc_pkg::TSCC_ACT_CLEAR, 0, 2);
    stat_case(tscc_pkg::TSCC_ACT_HALVE, 4, 6);
    @(negedge ref_clk_in);
    chk("halve done", 0, stat_done);
    summarize();
  end
endmodule : tb_top
